// ==== src/sdp_pkg.sv ====
// package of constants for the single wire debug port
package sdp_pkg;
    // ------------------------------------------------------------
    // timing in system clock cycles
    // ------------------------------------------------------------
    localparam int BIT_PERIOD = 16;
    localparam int SAMPLE_DLY = 10;
    localparam int SPEEDUP_ONE = 7;
    localparam int ZERO_LOW = 13;
    localparam int TIMEOUT_CYC = 512;
    localparam int STEAL_CYC = 128;
    localparam int RESUME_DLY = 4;
    localparam int CNT_W = 10;
    // ------------------------------------------------------------
    // debug map addresses; cpu hits decode only while debug mode is active, debug commands reach them in any mode
    // ------------------------------------------------------------
    localparam logic [15:0] DBG_BASE = 16'hFF00;
    localparam logic [15:0] DBG_REG_LAST = 16'hFF06;
    localparam logic [15:0] STATUS_ADDR = 16'hFF01;
    localparam int FW_EN_BIT = 7;
    localparam logic [7:0] STATUS_RST = 8'h00;
    // ------------------------------------------------------------
    // hardware command codes
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_BACKGROUND = 8'h90;
    localparam logic [7:0] CMD_READ_DBG_BYTE = 8'hE4;
    localparam logic [7:0] CMD_READ_DBG_WORD = 8'hEC;
    localparam logic [7:0] CMD_READ_BYTE = 8'hE0;
    localparam logic [7:0] CMD_READ_WORD = 8'hE8;
    localparam logic [7:0] CMD_WRITE_DBG_BYTE = 8'hC4;
    localparam logic [7:0] CMD_WRITE_DBG_WORD = 8'hCC;
    localparam logic [7:0] CMD_WRITE_BYTE = 8'hC0;
    localparam logic [7:0] CMD_WRITE_WORD = 8'hC8;
    localparam int FIELD_W = 16;
endpackage : sdp_pkg

// ==== src/sdp_bit_engine.sv ====
// one bit time of the debug wire: receive sample or transmit drive
`timescale 1ns/1ps
module sdp_bit_engine
    import sdp_pkg::*;
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic wire_i,
    input wire logic tx_mode_i,
    input wire logic tx_bit_i,
    output logic wire_o,
    output logic wire_oe_o,
    output logic rx_valid_o,
    output logic rx_bit_o,
    output logic tx_done_o,
    output logic timeout_o
);
    logic wire_q;
    logic busy;
    logic tx_cur;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] idle;
    logic fall;

    // edge detect on registered wire (input is synchronous to the clock)
    assign fall = wire_q & ~wire_i;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wire_q <= 1'b1;
        end else begin
            wire_q <= wire_i;
        end
    end

    // ------------------------------------------------------------
    // bit timer, started by a host falling edge while no window is open
    // ------------------------------------------------------------
    // edges during an open window are ignored; host must wait a bit period
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            busy <= 1'b0;
            cnt <= '0;
            tx_cur <= 1'b0;
        end else if (!busy && fall) begin
            busy <= 1'b1;
            cnt <= CNT_W'(1);
            tx_cur <= tx_mode_i;
        end else if (busy) begin
            cnt <= cnt + CNT_W'(1);
            if (cnt == CNT_W'(BIT_PERIOD - 1)) begin
                busy <= 1'b0;
            end
        end
    end

    // receive sample ten cycles after the perceived start
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rx_valid_o <= 1'b0;
            rx_bit_o <= 1'b0;
        end else begin
            rx_valid_o <= busy && !tx_cur && cnt == CNT_W'(SAMPLE_DLY);
            if (busy && !tx_cur && cnt == CNT_W'(SAMPLE_DLY)) begin
                rx_bit_o <= wire_i;
            end
        end
    end

    // ------------------------------------------------------------
    // transmit drive: low for a zero, one-cycle high speed-up pulse
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wire_o <= 1'b1;
            wire_oe_o <= 1'b0;
            tx_done_o <= 1'b0;
        end else begin
            tx_done_o <= busy && tx_cur && cnt == CNT_W'(BIT_PERIOD - 1);
            wire_o <= 1'b1;
            wire_oe_o <= 1'b0;
            if (busy && tx_cur) begin
                if (tx_bit_i && cnt == CNT_W'(SPEEDUP_ONE)) begin
                    wire_oe_o <= 1'b1;
                end else if (!tx_bit_i && cnt < CNT_W'(ZERO_LOW)) begin
                    wire_o <= 1'b0;
                    wire_oe_o <= 1'b1;
                end else if (!tx_bit_i && cnt == CNT_W'(ZERO_LOW)) begin
                    wire_oe_o <= 1'b1;
                end
            end
        end
    end

    // idle watchdog between host falling edges
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            idle <= '0;
            timeout_o <= 1'b0;
        end else begin
            timeout_o <= 1'b0;
            if (fall) begin
                idle <= '0;
            end else if (idle == CNT_W'(TIMEOUT_CYC - 1)) begin
                idle <= '0;
                timeout_o <= 1'b1;
            end else begin
                idle <= idle + CNT_W'(1);
            end
        end
    end
endmodule : sdp_bit_engine

// ==== src/sdp_debug_port.sv ====
// single wire debug port: serial commands, debug mode control, memory steal
`timescale 1ns/1ps
module sdp_debug_port
    import sdp_pkg::*;
(
    input wire logic CLK_SYS_I,
    input wire logic RESETN_I,
    input wire logic DEBUG_WIRE_PIN_I,
    output logic DEBUG_WIRE_PIN_O,
    output logic DEBUG_WIRE_PIN_OE_O,
    input wire logic SPECIAL_SINGLE_CHIP_I,
    input wire logic TAG_HIT_I,
    input wire logic BACKGROUND_INSTRUCTION_I,
    input wire logic INSTR_BOUNDARY_I,
    input wire logic BUS_FREE_I,
    input wire logic [7:0] MEM_RDATA_I,
    input wire logic [15:0] CPU_ADDR_I,
    input wire logic [7:0] PERIPH_SUSPEND_I,
    output logic MEM_REQ_O,
    output logic MEM_WRITE_O,
    output logic MEM_DBG_MAP_O,
    output logic [15:0] MEM_ADDR_O,
    output logic [7:0] MEM_WDATA_O,
    output logic CPU_FREEZE_O,
    output logic BACKGROUND_ACTIVE_O,
    output logic FIRMWARE_ENABLE_O,
    output logic FW_CMD_ALLOWED_O,
    output logic DBG_MAP_HIT_O,
    output logic DBG_REG_HIT_O,
    output logic [7:0] PERIPH_HALT_O,
    output logic [7:0] STATUS_O
);
    typedef enum {ST_CMD, ST_ADDR, ST_WDATA, ST_MEM, ST_RDATA} sdp_state_e;
    sdp_state_e state;

    logic rx_valid;
    logic rx_bit;
    logic tx_done;
    logic timeout;
    logic tx_mode;
    logic tx_bit;
    logic [7:0] cmd;
    logic [FIELD_W-1:0] shreg;
    logic [4:0] nbits;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic [7:0] steal_cnt;
    logic firmware_enable_bit;
    logic active;
    logic bg_pending;
    logic [2:0] resume_cnt;
    logic strap_done;
    logic is_write;
    logic is_dbg;
    logic is_word;
    logic mem_go;
    logic [15:0] next_shift;

    // ------------------------------------------------------------
    // bit timing engine
    // ------------------------------------------------------------
    sdp_bit_engine u_bit (
        .clk_i(CLK_SYS_I),
        .resetn_i(RESETN_I),
        .wire_i(DEBUG_WIRE_PIN_I),
        .tx_mode_i(tx_mode),
        .tx_bit_i(tx_bit),
        .wire_o(DEBUG_WIRE_PIN_O),
        .wire_oe_o(DEBUG_WIRE_PIN_OE_O),
        .rx_valid_o(rx_valid),
        .rx_bit_o(rx_bit),
        .tx_done_o(tx_done),
        .timeout_o(timeout)
    );

    // command decode
    assign is_write = (cmd[7:4] == 4'hC);
    assign is_dbg = cmd[2];
    assign is_word = cmd[3];
    assign tx_mode = (state == ST_RDATA);
    assign tx_bit = rdata[15];
    assign next_shift = {shreg[14:0], rx_bit};
    // grab the bus on a dead cycle or once the steal timer expires
    assign mem_go = (state == ST_MEM) && (BUS_FREE_I || CPU_FREEZE_O);

    // ------------------------------------------------------------
    // serial command sequencer; no mode gating, works in all modes
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            state <= ST_CMD;
            cmd <= 8'h00;
            shreg <= '0;
            nbits <= 5'h00;
            addr <= 16'h0000;
            wdata <= 16'h0000;
            rdata <= 16'h0000;
        end else if (timeout) begin
            state <= ST_CMD;
            cmd <= 8'h00;
            nbits <= 5'h00;
        end else begin
            case (state)
                ST_CMD: begin
                    if (rx_valid) begin
                        shreg <= next_shift;
                        nbits <= nbits + 5'h01;
                        if (nbits == 5'h07) begin
                            cmd <= next_shift[7:0];
                            nbits <= 5'h00;
                            if (next_shift[7:0] != CMD_BACKGROUND && next_shift[7] && next_shift[6]) begin
                                state <= ST_ADDR;
                            end
                        end
                    end
                end
                ST_ADDR: begin
                    if (rx_valid) begin
                        shreg <= next_shift;
                        nbits <= nbits + 5'h01;
                        if (nbits == 5'h0F) begin
                            addr <= next_shift;
                            nbits <= 5'h00;
                            state <= is_write ? ST_WDATA : ST_MEM;
                        end
                    end
                end
                ST_WDATA: begin
                    if (rx_valid) begin
                        shreg <= next_shift;
                        nbits <= nbits + 5'h01;
                        if (nbits == 5'h0F) begin
                            wdata <= next_shift;
                            nbits <= 5'h00;
                            state <= ST_MEM;
                        end
                    end
                end
                ST_MEM: begin
                    if (mem_go) begin
                        // odd address or word access on low lane, even byte address on high lane
                        rdata <= (addr[0] || is_word) ? {8'h00, MEM_RDATA_I} : {MEM_RDATA_I, 8'h00};
                        state <= is_write ? ST_CMD : ST_RDATA;
                    end
                end
                ST_RDATA: begin
                    if (tx_done) begin
                        rdata <= {rdata[14:0], 1'b0};
                        nbits <= nbits + 5'h01;
                        if (nbits == 5'h0F) begin
                            nbits <= 5'h00;
                            state <= ST_CMD;
                        end
                    end
                end
                default: state <= ST_CMD;
            endcase
        end
    end

    // memory access strobe, single cycle per command (byte lane model)
    always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            MEM_REQ_O <= 1'b0;
            MEM_WRITE_O <= 1'b0;
            MEM_DBG_MAP_O <= 1'b0;
            MEM_ADDR_O <= 16'h0000;
            MEM_WDATA_O <= 8'h00;
        end else begin
            // one pulse, the cycle after the grant, so address and data stand with it
            MEM_REQ_O <= mem_go;
            MEM_WRITE_O <= is_write;
            MEM_DBG_MAP_O <= is_dbg;
            MEM_ADDR_O <= addr;
            MEM_WDATA_O <= (addr[0] || is_word) ? wdata[7:0] : wdata[15:8];
        end
    end

    // steal timer: freeze the cpu after 128 cycles without a dead cycle
    always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            steal_cnt <= 8'h00;
            CPU_FREEZE_O <= 1'b0;
        end else if (state != ST_MEM || mem_go) begin
            steal_cnt <= 8'h00;
            CPU_FREEZE_O <= 1'b0;
        end else if (steal_cnt == 8'(STEAL_CYC - 1)) begin
            CPU_FREEZE_O <= 1'b1;
        end else begin
            steal_cnt <= steal_cnt + 8'h01;
        end
    end

    // ------------------------------------------------------------
    // firmware enable, activation and resume
    // ------------------------------------------------------------
    // strap is caught at the first clocked edge after release, not in reset
    always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            strap_done <= 1'b0;
            firmware_enable_bit <= STATUS_RST[FW_EN_BIT];
            active <= 1'b0;
            bg_pending <= 1'b0;
            resume_cnt <= 3'h0;
        end else begin
            strap_done <= 1'b1;
            if (!strap_done && SPECIAL_SINGLE_CHIP_I) begin
                firmware_enable_bit <= 1'b1;
                active <= 1'b1;
            end
            if (mem_go && is_write && is_dbg && addr == STATUS_ADDR) begin
                firmware_enable_bit <= wdata[FW_EN_BIT];
            end
            if (state == ST_CMD && rx_valid && nbits == 5'h07 && next_shift[7:0] == CMD_BACKGROUND) begin
                bg_pending <= 1'b1;
            end
            if (TAG_HIT_I || BACKGROUND_INSTRUCTION_I || (bg_pending && INSTR_BOUNDARY_I)) begin
                bg_pending <= 1'b0;
                if (firmware_enable_bit) begin
                    active <= 1'b1;
                end else begin
                    resume_cnt <= 3'(RESUME_DLY);
                end
            end else if (resume_cnt != 3'h0) begin
                resume_cnt <= resume_cnt - 3'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // map decode and status view
    // ------------------------------------------------------------
    assign BACKGROUND_ACTIVE_O = active;
    assign FIRMWARE_ENABLE_O = firmware_enable_bit;
    assign FW_CMD_ALLOWED_O = active;
    assign DBG_MAP_HIT_O = active && (CPU_ADDR_I >= DBG_BASE);
    assign DBG_REG_HIT_O = active && (CPU_ADDR_I <= DBG_REG_LAST) && (CPU_ADDR_I >= DBG_BASE);
    assign STATUS_O = {firmware_enable_bit, active, 6'h00};

    // per-peripheral suspend during debug mode
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_susp
            assign PERIPH_HALT_O[g] = active & PERIPH_SUSPEND_I[g];
        end
    endgenerate
endmodule : sdp_debug_port

// ==== test/sdp_debug_port_properties.sv ====
// assertion checker for the single wire debug port
`timescale 1ns/1ps
module sdp_debug_port_checker
    import sdp_pkg::*;
(
    input wire logic CLK_SYS_I,
    input wire logic RESETN_I,
    input wire logic DEBUG_WIRE_PIN_O,
    input wire logic DEBUG_WIRE_PIN_OE_O,
    input wire logic BUS_FREE_I,
    input wire logic [15:0] CPU_ADDR_I,
    input wire logic [7:0] PERIPH_SUSPEND_I,
    input wire logic MEM_REQ_O,
    input wire logic CPU_FREEZE_O,
    input wire logic BACKGROUND_ACTIVE_O,
    input wire logic FIRMWARE_ENABLE_O,
    input wire logic FW_CMD_ALLOWED_O,
    input wire logic DBG_MAP_HIT_O,
    input wire logic DBG_REG_HIT_O,
    input wire logic [7:0] PERIPH_HALT_O,
    input wire logic [7:0] STATUS_O
);
    // ------------------------------------------------------------
    // helper counters
    // ------------------------------------------------------------
    logic [9:0] busy_cnt;
    logic [4:0] drive_cnt;
    // busy bus cycles in a row, saturating so it never wraps
    always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            busy_cnt <= 10'h000;
        end else if (BUS_FREE_I) begin
            busy_cnt <= 10'h000;
        end else if (busy_cnt != 10'h3FF) begin
            busy_cnt <= busy_cnt + 10'h001;
        end
    end
    // cycles in a row the device drives the wire
    always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            drive_cnt <= 5'h00;
        end else if (!DEBUG_WIRE_PIN_OE_O) begin
            drive_cnt <= 5'h00;
        end else if (drive_cnt != 5'h1F) begin
            drive_cnt <= drive_cnt + 5'h01;
        end
    end
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!RESETN_I);
    sequence s_freeze_start; $rose(CPU_FREEZE_O); endsequence
    sequence s_speedup; DEBUG_WIRE_PIN_OE_O && DEBUG_WIRE_PIN_O; endsequence
    property p_halt; PERIPH_HALT_O == (BACKGROUND_ACTIVE_O ? PERIPH_SUSPEND_I : 8'h00); endproperty
    a_halt: assert property (p_halt) else $error("halt does not follow debug mode");
    property p_map; DBG_MAP_HIT_O == (BACKGROUND_ACTIVE_O && CPU_ADDR_I >= DBG_BASE); endproperty
    a_map: assert property (p_map) else $error("debug map hit wrong");
    property p_reg;
        DBG_REG_HIT_O == (BACKGROUND_ACTIVE_O && CPU_ADDR_I >= DBG_BASE && CPU_ADDR_I <= DBG_REG_LAST);
    endproperty
    a_reg: assert property (p_reg) else $error("debug register hit wrong");
    property p_status; STATUS_O == {FIRMWARE_ENABLE_O, BACKGROUND_ACTIVE_O, 6'h00}; endproperty
    a_status: assert property (p_status) else $error("status byte wrong");
    property p_fw_cmd; FW_CMD_ALLOWED_O |-> BACKGROUND_ACTIVE_O; endproperty
    a_fw_cmd: assert property (p_fw_cmd) else $error("firmware command outside background");
    property p_active_fw; $rose(BACKGROUND_ACTIVE_O) |-> FIRMWARE_ENABLE_O; endproperty
    a_active_fw: assert property (p_active_fw) else $error("activated without firmware");
    property p_speedup; s_speedup |=> !DEBUG_WIRE_PIN_OE_O; endproperty
    a_speedup: assert property (p_speedup) else $error("speed-up pulse too long");
    property p_release_high; $fell(DEBUG_WIRE_PIN_OE_O) |-> $past(DEBUG_WIRE_PIN_O); endproperty
    a_release_high: assert property (p_release_high) else $error("wire released from low");
    property p_drive_len; drive_cnt <= 5'd14; endproperty
    a_drive_len: assert property (p_drive_len) else $error("device drives wire too long");
    property p_freeze_late; s_freeze_start |-> busy_cnt >= 10'd127; endproperty
    a_freeze_late: assert property (p_freeze_late) else $error("freeze too early");
    property p_freeze_req; s_freeze_start |-> ##[0:4] MEM_REQ_O; endproperty
    a_freeze_req: assert property (p_freeze_req) else $error("freeze without access");
    property p_req_grant; MEM_REQ_O |-> $past(BUS_FREE_I) || $past(CPU_FREEZE_O); endproperty
    a_req_grant: assert property (p_req_grant) else $error("access without free cycle");
    property p_req_pulse; MEM_REQ_O |=> !MEM_REQ_O; endproperty
    a_req_pulse: assert property (p_req_pulse) else $error("access pulse too long");
endmodule : sdp_debug_port_checker

// ==== test/sdp_host_model.sv ====
// host development system model driving the debug wire
`timescale 1ns/1ps
module sdp_host_model (
    input wire logic clk_i,
    input wire logic wire_i,
    output logic host_o,
    output logic host_oe_o
);
    // released at start, the pull-up holds the line high
    initial begin
        host_o = 1'b1;
        host_oe_o = 1'b0;
    end
    // one bit to the device; four cycles low, then the bit level held past its sample point
    task automatic send_bit(input logic b);
        @(negedge clk_i);
        host_oe_o = 1'b1;
        host_o = 1'b0;
        repeat (4) @(negedge clk_i);
        host_o = b;
        repeat (10) @(negedge clk_i);
        host_o = 1'b1;
        repeat (2) @(negedge clk_i);
        host_oe_o = 1'b0;
        repeat (5) @(negedge clk_i);
    endtask : send_bit
    // low n bits of v, most significant first
    task automatic send_bits(input logic [39:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            send_bit(v[i]);
        end
    endtask : send_bits
    // n bits from the device; release before its speed-up pulse
    task automatic recv_bits(input int n, output logic [15:0] v);
        v = 16'h0000;
        for (int i = 0; i < n; i++) begin
            @(negedge clk_i);
            host_oe_o = 1'b1;
            host_o = 1'b0;
            repeat (2) @(negedge clk_i);
            host_oe_o = 1'b0;
            repeat (8) @(negedge clk_i);
            v = {v[14:0], wire_i};
            repeat (11) @(negedge clk_i);
        end
    endtask : recv_bits
endmodule : sdp_host_model

// ==== test/tb_top.sv ====
// self-checking bench for the single wire debug port
`timescale 1ns/1ps
`define CHK(what, exp, got) begin n_compared++; if ((got) !== (exp)) begin miscompares++; \
    $display("mismatch %s expected %h seen %h", what, exp, got); end end
module tb_top;
    import sdp_pkg::*;
    logic clk_sys, resetn, strap, tag_hit, bg_instr, boundary, bus_free, req_write, req_map;
    logic host_o, host_oe, dbg_wire, dev_o, dev_oe, req, mem_write, mem_map, freeze;
    logic active, fw_en, fw_ok, map_hit, reg_hit;
    logic [7:0] rdata, suspend, wdata, halt, status, req_wdata;
    logic [15:0] cpu_addr, mem_addr, req_addr, rx;
    int n_req, miscompares, n_compared;
    // device drive wins, else host, else the pull-up
    assign dbg_wire = dev_oe ? dev_o : (host_oe ? host_o : 1'b1);
    sdp_debug_port sdp_debug_port_i (.CLK_SYS_I(clk_sys), .RESETN_I(resetn), .DEBUG_WIRE_PIN_I(dbg_wire),
        .DEBUG_WIRE_PIN_O(dev_o), .DEBUG_WIRE_PIN_OE_O(dev_oe), .SPECIAL_SINGLE_CHIP_I(strap),
        .TAG_HIT_I(tag_hit), .BACKGROUND_INSTRUCTION_I(bg_instr), .INSTR_BOUNDARY_I(boundary),
        .BUS_FREE_I(bus_free), .MEM_RDATA_I(rdata), .CPU_ADDR_I(cpu_addr), .PERIPH_SUSPEND_I(suspend),
        .MEM_REQ_O(req), .MEM_WRITE_O(mem_write), .MEM_DBG_MAP_O(mem_map), .MEM_ADDR_O(mem_addr),
        .MEM_WDATA_O(wdata), .CPU_FREEZE_O(freeze), .BACKGROUND_ACTIVE_O(active), .FIRMWARE_ENABLE_O(fw_en),
        .FW_CMD_ALLOWED_O(fw_ok), .DBG_MAP_HIT_O(map_hit), .DBG_REG_HIT_O(reg_hit), .PERIPH_HALT_O(halt),
        .STATUS_O(status));
    sdp_host_model sdp_host_model_i (.clk_i(clk_sys), .wire_i(dbg_wire), .host_o(host_o), .host_oe_o(host_oe));
    // 40 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    // latch each memory access; sampled mid-cycle so it is settled
    always @(negedge clk_sys) begin
        if (req === 1'b1) begin
            n_req++;
            req_addr = mem_addr;
            req_wdata = wdata;
            req_write = mem_write;
            req_map = mem_map;
        end
    end
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : complete_run
    task automatic do_reset(input logic s);
        strap = s;
        resetn = 1'b0;
        repeat (2) @(negedge clk_sys);
        resetn = 1'b1;
        repeat (2) @(negedge clk_sys);
    endtask : do_reset
    // write, then grant one free bus cycle until the access shows
    task automatic write_free(input logic [7:0] cmd, input logic [15:0] addr, input logic [15:0] data);
        int start;
        start = n_req;
        sdp_host_model_i.send_bits({cmd, addr, data}, 40);
        bus_free = 1'b1;
        for (int i = 0; i < 50 && n_req == start; i++) @(negedge clk_sys);
        bus_free = 1'b0;
        `CHK("access count", start + 1, n_req)
    endtask : write_free
    task automatic t_no_fw;
        sdp_host_model_i.send_bits({32'h0, CMD_BACKGROUND}, 8);
        boundary = 1'b1;
        tag_hit = 1'b1;
        bg_instr = 1'b1;
        @(negedge clk_sys);
        boundary = 1'b0;
        tag_hit = 1'b0;
        bg_instr = 1'b0;
        repeat (RESUME_DLY + 8) @(negedge clk_sys);
        `CHK("active", 1'b0, active)
        `CHK("fw cmd", 1'b0, fw_ok)
        `CHK("map hit", 1'b0, map_hit)
        `CHK("halt", 8'h00, halt)
        `CHK("wire enable", 1'b0, dev_oe)
    endtask : t_no_fw
    // partial command left idle must be dropped before the enable
    task automatic t_enable;
        sdp_host_model_i.send_bits({36'h0, 4'hC}, 4);
        repeat (TIMEOUT_CYC + 80) @(negedge clk_sys);
        write_free(CMD_WRITE_DBG_BYTE, STATUS_ADDR, 16'h0080);
        `CHK("fw enable", 1'b1, fw_en)
        `CHK("enable addr", STATUS_ADDR, req_addr)
        `CHK("enable data", 8'h80, req_wdata)
        `CHK("enable map", 1'b1, req_map)
        `CHK("status", 8'h80, status)
    endtask : t_enable
    task automatic t_background;
        logic [15:0] addrs [5] = '{16'hFEFF, 16'hFF00, 16'hFF06, 16'hFF07, 16'hFFFF};
        sdp_host_model_i.send_bits({32'h0, CMD_BACKGROUND}, 8);
        repeat (40) @(negedge clk_sys);
        `CHK("active early", 1'b0, active)
        boundary = 1'b1;
        @(negedge clk_sys);
        boundary = 1'b0;
        @(negedge clk_sys);
        `CHK("active", 1'b1, active)
        `CHK("fw cmd", 1'b1, fw_ok)
        suspend = 8'hA5;
        @(negedge clk_sys);
        `CHK("halt", 8'hA5, halt)
        for (int i = 0; i < 5; i++) begin
            cpu_addr = addrs[i];
            @(negedge clk_sys);
            `CHK("map hit", 5'b11110 >> i & 5'h01, {4'h0, map_hit})
            `CHK("reg hit", 5'b00110 >> i & 5'h01, {4'h0, reg_hit})
        end
    endtask : t_background
    task automatic t_read;
        rdata = 8'h5A;
        bus_free = 1'b1;
        sdp_host_model_i.send_bits({16'h0, CMD_READ_BYTE, 16'h1000}, 24);
        repeat (10) @(negedge clk_sys);
        bus_free = 1'b0;
        sdp_host_model_i.recv_bits(16, rx);
        `CHK("read data", 8'h5A, rx[15:8])
        `CHK("read addr", 16'h1000, req_addr)
        `CHK("read kind", 1'b0, req_write)
        `CHK("read map", 1'b0, req_map)
        // word read in the debug map: only the low byte travels
        rdata = 8'h3C;
        bus_free = 1'b1;
        sdp_host_model_i.send_bits({16'h0, CMD_READ_DBG_WORD, 16'hFF02}, 24);
        repeat (10) @(negedge clk_sys);
        bus_free = 1'b0;
        sdp_host_model_i.recv_bits(16, rx);
        `CHK("word data", 16'h003C, rx)
        `CHK("word addr", 16'hFF02, req_addr)
        `CHK("word map", 1'b1, req_map)
    endtask : t_read
    // bus never free: the write must steal a cycle
    task automatic t_steal;
        int cnt;
        cnt = 0;
        sdp_host_model_i.send_bits({CMD_WRITE_BYTE, 16'h2000, 16'hC300}, 40);
        while (freeze !== 1'b1 && cnt < 300) begin
            @(negedge clk_sys);
            cnt++;
        end
        `CHK("freeze time", 1'b1, cnt >= 100 && cnt <= 130)
        repeat (4) @(negedge clk_sys);
        `CHK("steal data", 8'hC3, req_wdata)
        `CHK("steal addr", 16'h2000, req_addr)
    endtask : t_steal
    task automatic t_activate(input int src);
        do_reset(1'b0);
        write_free(CMD_WRITE_DBG_BYTE, STATUS_ADDR, 16'h0080);
        `CHK("idle", 1'b0, active)
        if (src == 0) tag_hit = 1'b1;
        else bg_instr = 1'b1;
        @(negedge clk_sys);
        tag_hit = 1'b0;
        bg_instr = 1'b0;
        @(negedge clk_sys);
        `CHK("activated", 1'b1, active)
    endtask : t_activate
    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        {resetn, strap, tag_hit, bg_instr, boundary, bus_free} = 6'h00;
        {rdata, suspend, cpu_addr} = 32'h00FF_FF00;
        do_reset(1'b0);
        `CHK("reset wire level", 1'b1, dev_o)
        `CHK("reset status", STATUS_RST, status)
        t_no_fw;
        t_enable;
        t_background;
        t_read;
        t_steal;
        for (int s = 0; s < 2; s++) t_activate(s);
        do_reset(1'b1);
        `CHK("strap enable", 1'b1, fw_en)
        `CHK("strap active", 1'b1, active)
        complete_run;
    end
    // the run needs about 6500 cycles
    initial begin
        repeat (60000) @(posedge clk_sys);
        miscompares++;
        complete_run;
    end
endmodule : tb_top
bind sdp_debug_port sdp_debug_port_checker sdp_debug_port_checker_i (.CLK_SYS_I, .RESETN_I, .DEBUG_WIRE_PIN_O,
    .DEBUG_WIRE_PIN_OE_O, .BUS_FREE_I, .CPU_ADDR_I, .PERIPH_SUSPEND_I, .MEM_REQ_O, .CPU_FREEZE_O,
    .BACKGROUND_ACTIVE_O, .FIRMWARE_ENABLE_O, .FW_CMD_ALLOWED_O, .DBG_MAP_HIT_O, .DBG_REG_HIT_O,
    .PERIPH_HALT_O, .STATUS_O);
